// ### hw/edq_consts.svh
// constants for the edge delay qualifier: timing, offsets, divide ratios
// assumes a 200 MHz pclk and the register map decoded on paddr[7:0]
`ifndef EDQ_CONSTS_SVH
`define EDQ_CONSTS_SVH

// =====================================================================
// clock and master period
`define EDQ_CLK_NS       5
`define EDQ_MASTER_NS    1000
`define EDQ_PERIOD_RST   16'(`EDQ_MASTER_NS / `EDQ_CLK_NS)

// =====================================================================
// register map (byte addresses)
`define EDQ_OFS_PERIOD   8'h00
`define EDQ_OFS_STATUS   8'h04

// =====================================================================
// start-up and code filter
`define EDQ_START_LAST   9'h1F3
`define EDQ_CODE_BIAS    5'h06
`define EDQ_POL_BIT      3

// =====================================================================
// divide ratios in master periods, index 0 to 7
`define EDQ_R0           22'h000001
`define EDQ_R1           22'h000008
`define EDQ_R2           22'h000040
`define EDQ_R3           22'h000200
`define EDQ_R4           22'h001000
`define EDQ_R5           22'h008000
`define EDQ_R6           22'h040000
`define EDQ_R7           22'h200000

`endif

// ### hw/edq_pkg.sv
// types shared by the edge delay qualifier
// assumes edq_consts.svh supplies the numeric constants
package edq_pkg;

  // =====================================================================
  // edge engine states
  typedef enum logic [1:0] {
    EDQ_START = 2'b00,
    EDQ_IDLE  = 2'b01,
    EDQ_TIME  = 2'b10
  } edq_state_t;

  // =====================================================================
  // register decode result
  typedef enum logic [1:0] {
    EDQ_DEC_NONE   = 2'b00,
    EDQ_DEC_PERIOD = 2'b01,
    EDQ_DEC_STATUS = 2'b10
  } edq_dec_t;

endpackage : edq_pkg

// ### hw/edq_top.sv
// edge delay qualifier: delays and qualifies edges of one logic input
// assumes sig_in and raw_code arrive asynchronously; software on APB
//
// Notes on behaviour
// [RULE_01] eight divide ratios from 1 to 2^21
// [RULE_02] delay equals ratio times master period
// [RULE_03] 4-bit selection code sets ratio and polarity
// [RULE_04] code top bit is the polarity bit
// [RULE_05] codes 8-15 mirror ratios, polarity set
// [RULE_06] select voltage ratio is (code+0.5)/16
// [RULE_07] single-edge pol 0: rising edge delayed, qualified
// [RULE_08] early drop leaves output; rising edge restarts
// [RULE_09] single-edge pol 0: falling edge passes at once
// [RULE_10] polarity 1 swaps delayed and passed edges
// [RULE_11] both-edge variant delays each edge fully
// [RULE_12] short level restarts timing, output unchanged
// [RULE_13] both-edge polarity 1 inverts the output
// [RULE_14] both-edge output pulses last the delay
// [RULE_15] new code adopted after 16*(diff+6) periods
// [RULE_16] code filtered, no intermediate codes adopted
// [RULE_17] code change mid-delay gives in-between delay
// [RULE_18] start-up: output low, input ignored, 500 periods
// [RULE_19] start-up end copies input, maybe inverted
// [RULE_20] stopped oscillator holds delay until restart
// [RULE_21] variant is a static build parameter
// [RULE_22] synchronise input, count delays in master ticks
`timescale 1ns/10ps
`include "edq_consts.svh"

module edq_top
  import edq_pkg::*;
#(
  parameter bit BOTH_EDGES = 1'b0
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        sig_in,
  input  wire logic [3:0]  raw_code,
  output logic             sig_out
);

  // =====================================================================
  // declarations
  logic        in_meta_reg;
  logic        in_sync_reg;
  logic        in_prev_reg;
  logic [3:0]  code_meta_reg;
  logic [3:0]  code_sync_reg;
  logic [15:0] period_reg;
  logic [15:0] tick_cnt_reg;
  logic        tick_reg;
  edq_state_t  state_reg;
  logic [8:0]  start_cnt_reg;
  logic [21:0] delay_cnt_reg;
  logic        sig_out_reg;
  logic [3:0]  active_code_reg;
  logic [3:0]  cand_code_reg;
  logic [8:0]  filt_cnt_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [21:0] gap_ticks_reg;
  logic        gap_out_reg;
  logic [3:0]  gap_code_reg;

  logic        started;
  logic        edge_polarity_bit;
  logic        want;
  logic        dlvl;
  logic        edge_seen;
  logic [21:0] ratio;
  logic        done;
  logic        start_end;
  logic        start_lvl;
  logic [8:0]  filt_target;
  logic        filt_adopt;
  logic        apb_done;
  edq_dec_t    dec;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // =====================================================================
  // decode helpers
  function automatic logic [21:0] edq_ratio(input logic [3:0] code);
    logic [2:0] idx;
    idx = code[`EDQ_POL_BIT] ? ~code[2:0] : code[2:0];
    unique case (idx)
      3'h0: edq_ratio = `EDQ_R0;
      3'h1: edq_ratio = `EDQ_R1;
      3'h2: edq_ratio = `EDQ_R2;
      3'h3: edq_ratio = `EDQ_R3;
      3'h4: edq_ratio = `EDQ_R4;
      3'h5: edq_ratio = `EDQ_R5;
      3'h6: edq_ratio = `EDQ_R6;
      3'h7: edq_ratio = `EDQ_R7;
    endcase
  endfunction : edq_ratio

  function automatic logic [3:0] edq_absdiff(input logic [3:0] a,
                                             input logic [3:0] b);
    edq_absdiff = (a > b) ? 4'(a - b) : 4'(b - a);
  endfunction : edq_absdiff

  function automatic edq_dec_t edq_decode(input logic [7:0] addr);
    if (addr == `EDQ_OFS_PERIOD) begin
      edq_decode = EDQ_DEC_PERIOD;
    end else if (addr == `EDQ_OFS_STATUS) begin
      edq_decode = EDQ_DEC_STATUS;
    end else begin
      edq_decode = EDQ_DEC_NONE;
    end
  endfunction : edq_decode

  // =====================================================================
  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta_reg <= 1'b0;
      in_sync_reg <= 1'b0;
      in_prev_reg <= 1'b0;
    end else begin
      in_meta_reg <= sig_in;                          // [RULE_22]
      in_sync_reg <= in_meta_reg;
      in_prev_reg <= in_sync_reg;
    end
  end

  // the converter result settles slowly; the filter below rejects wander
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_meta_reg <= 4'h0;
      code_sync_reg <= 4'h0;
    end else begin
      code_meta_reg <= raw_code;                      // [RULE_03] [RULE_06]
      code_sync_reg <= code_meta_reg;
    end
  end

  // =====================================================================
  // combinational view of the edge engine
  assign started   = (state_reg != EDQ_START);
  assign edge_polarity_bit       = active_code_reg[`EDQ_POL_BIT];   // [RULE_04]
  assign want      = BOTH_EDGES ? (in_sync_reg ^ edge_polarity_bit) : in_sync_reg; // [RULE_13] [RULE_21]
  assign dlvl      = ~edge_polarity_bit;                            // [RULE_10]
  assign edge_seen = (in_sync_reg != in_prev_reg);
  assign ratio     = edq_ratio(active_code_reg);      // [RULE_01] [RULE_05]
  // >= lets a shorter ratio adopted mid-delay end the delay at the next tick
  assign done      = (state_reg == EDQ_TIME) && tick_reg &&
                     (({1'b0, delay_cnt_reg} + 23'h000001) >= {1'b0, ratio}); // [RULE_02] [RULE_17]
  assign start_end = (state_reg == EDQ_START) && tick_reg &&
                     (start_cnt_reg == `EDQ_START_LAST);
  assign start_lvl = BOTH_EDGES ? (in_sync_reg ^ code_sync_reg[`EDQ_POL_BIT])
                                : in_sync_reg;

  // =====================================================================
  // master oscillator: a period of zero stops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b0;
    end else if (period_reg == 16'h0000) begin
      tick_cnt_reg <= 16'h0000;                       // [RULE_20]
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg >= 16'(period_reg - 16'h0001)) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= 16'(tick_cnt_reg + 16'h0001);
      tick_reg     <= 1'b0;
    end
  end

  // =====================================================================
  // start-up interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_cnt_reg <= 9'h000;
    end else if ((state_reg == EDQ_START) && tick_reg) begin
      start_cnt_reg <= 9'(start_cnt_reg + 9'h001);    // [RULE_18]
    end
  end

  // =====================================================================
  // delay counter, in master ticks; any input edge restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_cnt_reg <= 22'h000000;
    end else if ((state_reg != EDQ_TIME) || edge_seen) begin
      delay_cnt_reg <= 22'h000000;                    // [RULE_08] [RULE_12]
    end else if (tick_reg) begin
      delay_cnt_reg <= 22'(delay_cnt_reg + 22'h000001); // [RULE_22]
    end
  end

  // =====================================================================
  // edge engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= EDQ_START;
      sig_out_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        EDQ_START: begin
          sig_out_reg <= 1'b0;                        // [RULE_18]
          if (start_end) begin
            sig_out_reg <= start_lvl;                 // [RULE_19]
            state_reg   <= EDQ_IDLE;
          end
        end
        EDQ_IDLE, EDQ_TIME: begin
          if (!BOTH_EDGES && (want != dlvl)) begin
            sig_out_reg <= want;                      // [RULE_09] [RULE_10]
            state_reg   <= EDQ_IDLE;
          end else if (want == sig_out_reg) begin
            state_reg   <= EDQ_IDLE;                  // [RULE_08] [RULE_12]
          end else if (edge_seen || (state_reg == EDQ_IDLE)) begin
            state_reg   <= EDQ_TIME;                  // [RULE_07] [RULE_11]
          end else if (done) begin
            sig_out_reg <= want;                      // [RULE_07] [RULE_11] [RULE_14]
            state_reg   <= EDQ_IDLE;
          end
        end
        default: begin
          state_reg   <= EDQ_START;
          sig_out_reg <= 1'b0;
        end
      endcase
    end
  end

  // =====================================================================
  // selection code filter
  assign filt_target = {5'({1'b0, edq_absdiff(cand_code_reg, active_code_reg)}
                           + `EDQ_CODE_BIAS), 4'h0};  // [RULE_15]
  assign filt_adopt  = started && tick_reg && (cand_code_reg == code_sync_reg) &&
                       (cand_code_reg != active_code_reg) &&
                       ((filt_cnt_reg + 9'h001) >= filt_target);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_code_reg <= 4'h0;
      cand_code_reg   <= 4'h0;
      filt_cnt_reg    <= 9'h000;
    end else if (start_end) begin
      active_code_reg <= code_sync_reg;               // [RULE_18]
      cand_code_reg   <= code_sync_reg;
      filt_cnt_reg    <= 9'h000;
    end else if (started) begin
      if (code_sync_reg != cand_code_reg) begin
        cand_code_reg <= code_sync_reg;               // [RULE_16]
        filt_cnt_reg  <= 9'h000;
      end else if (cand_code_reg == active_code_reg) begin
        filt_cnt_reg  <= 9'h000;
      end else if (filt_adopt) begin
        active_code_reg <= cand_code_reg;             // [RULE_15] [RULE_16]
        filt_cnt_reg    <= 9'h000;
      end else if (tick_reg) begin
        filt_cnt_reg  <= 9'(filt_cnt_reg + 9'h001);
      end
    end
  end

  // =====================================================================
  // apb slave: one wait state, then pready for one cycle
  assign dec      = edq_decode(paddr);
  assign apb_done = psel && penable && pready_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else if (psel && penable && !pready_reg) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= (dec == EDQ_DEC_NONE);
      prdata_reg  <= 32'h00000000;
      if (!pwrite && (dec == EDQ_DEC_PERIOD)) begin
        prdata_reg <= {16'h0000, period_reg};
      end else if (!pwrite && (dec == EDQ_DEC_STATUS)) begin
        prdata_reg <= {24'h000000, (cand_code_reg != active_code_reg),
                       (state_reg == EDQ_TIME), started, sig_out_reg,
                       active_code_reg};
      end
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // master period in pclk cycles; writing zero models a stopped oscillator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_reg <= `EDQ_PERIOD_RST;
    end else if (apb_done && pwrite && (dec == EDQ_DEC_PERIOD)) begin
      period_reg <= pwdata[15:0];                     // [RULE_02]
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign sig_out = sig_out_reg;

  // =====================================================================
  // checks
  startup_out_low_a: assert property ( // [RULE_18]
    !started |-> !sig_out_reg
  ) else $error("output not low during start-up");

  startup_copy_a: assert property ( // [RULE_19]
    $rose(started) |-> sig_out_reg == $past(start_lvl)
  ) else $error("start-up end did not copy input level");

  pass_through_a: assert property ( // [RULE_09]
    started && !BOTH_EDGES && (want != dlvl) |=> sig_out_reg == $past(want)
  ) else $error("passed edge not followed at once");

  delayed_edge_a: assert property ( // [RULE_11]
    started && $past(started) && (sig_out_reg != $past(sig_out_reg)) &&
    (BOTH_EDGES || (sig_out_reg == $past(dlvl))) |-> $past(done)
  ) else $error("delayed edge moved before delay ended");

  edge_restart_a: assert property ( // [RULE_12]
    started && edge_seen |=> delay_cnt_reg == 22'h000000
  ) else $error("input edge did not restart timing");

  code_latency_a: assert property ( // [RULE_15]
    started && $past(started) && $changed(active_code_reg) |-> $past(filt_adopt)
  ) else $error("code adopted before filter latency");

  no_wander_a: assert property ( // [RULE_16]
    started && $past(started) && $changed(active_code_reg)
      |-> active_code_reg == $past(code_sync_reg, 2)
  ) else $error("adopted code was not the stable code");

  osc_stop_a: assert property ( // [RULE_20]
    (period_reg == 16'h0000) && $past(period_reg == 16'h0000) |-> !tick_reg && !done
  ) else $error("delay advanced with oscillator stopped");

  apb_answer_a: assert property (
    psel && penable && !pready_reg |=> pready_reg ##1 !pready_reg
  ) else $error("apb answer not one wait state");

  // ticks since the output last moved; forced to the top when the code moves,
  // since a pulse timed across a code change may end between both settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_ticks_reg <= 22'h000000;
      gap_out_reg   <= 1'b0;
      gap_code_reg  <= 4'h0;
    end else begin
      gap_out_reg  <= sig_out_reg;
      gap_code_reg <= active_code_reg;
      if (gap_code_reg != active_code_reg) begin
        gap_ticks_reg <= 22'h3FFFFF;
      end else if (gap_out_reg != sig_out_reg) begin
        gap_ticks_reg <= 22'h000000;
      end else if (tick_reg && (gap_ticks_reg != 22'h3FFFFF)) begin
        gap_ticks_reg <= 22'(gap_ticks_reg + 22'h000001);
      end
    end
  end

  min_width_a: assert property ( // [RULE_14]
    BOTH_EDGES && started && $past(started) && (sig_out_reg != $past(sig_out_reg))
      |-> ($past({1'b0, gap_ticks_reg}) + 23'h000001) >= $past({1'b0, ratio})
  ) else $error("both-edge output pulse shorter than delay");

  idle_level_a: assert property ( // [RULE_13]
    BOTH_EDGES && (state_reg == EDQ_IDLE) && $past(state_reg == EDQ_IDLE)
      |-> $past(sig_out_reg == (in_sync_reg ^ active_code_reg[`EDQ_POL_BIT]))
  ) else $error("both-edge output not input xor polarity");

endmodule : edq_top

// ### sim/edq_noise_src.sv
// noisy source model: drives the qualifier input as a bouncing switch would
// assumes one bench process calls drive at a time
`timescale 1ns/10ps

module edq_noise_src (
  // clock
  input  wire logic pclk,
  // line to the qualifier
  output logic      line
);
  // ==========
  // changes land just after an edge so they never race the sampling flops
  initial line = 1'b0;

  task automatic drive(input logic v, input int hold);
    @(posedge pclk);
    line <= v;
    repeat (hold) @(posedge pclk);
  endtask : drive

endmodule : edq_noise_src

// ### sim/tb_edge_delay_qualifier.sv
// bench for the edge delay qualifier: single- and both-edge builds fed side by side
// assumes the qualifier top, its constants header and the noise source model
`timescale 1ns/10ps
`include "edq_consts.svh"

module tb_edge_delay_qualifier;
  // ==========
  // signals
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [3:0]  raw_code = 4'h1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sig_in;
  logic        sig_out;
  logic        sig_out2;
  int          bad_count = 0;
  int          tests_run = 0;
  int          seed      = 64609;
  int          cyc       = 0;
  int          cur_code  = 1;
  logic [3:0]  codes [10] = '{4'h0, 4'h2, 4'h4, 4'h3, 4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'h1};

  // ==========
  // both builds share bus and pins; only the first answers reads
  edq_top #(.BOTH_EDGES(1'b0)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sig_in(sig_in), .raw_code(raw_code),
    .sig_out(sig_out));
  edq_top #(.BOTH_EDGES(1'b1)) DUT2 (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .sig_in(sig_in), .raw_code(raw_code), .sig_out(sig_out2));
  edq_noise_src src (.pclk(pclk), .line(sig_in));

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  // ==========
  // checking and reporting
  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic fail(input string m);
    bad_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail

  task automatic chk_v(input logic [31:0] g, input logic [31:0] x, input string m);
    tests_run++;
    if (g !== x) fail($sformatf("%s got %0h want %0h", m, g, x));
  endtask : chk_v

  task automatic chk_r(input int n, input int lo, input int hi, input string m);
    tests_run++;
    if (n < lo || n > hi) fail($sformatf("%s took %0d want %0d..%0d", m, n, lo, hi));
  endtask : chk_r

  // with a one-cycle master period a tick is one pclk cycle
  function automatic int ratio(input logic [3:0] c);
    return 1 << (3 * (c[3] ? 15 - int'(c) : int'(c)));
  endfunction : ratio

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        return;
      end
    end
    fail("no bus answer");
    results();
  endtask : apb

  // cycles until each build shows its expected level
  task automatic meas(input logic x1, input logic x2, output int n1, output int n2);
    n1 = -1;
    n2 = -1;
    for (int i = 0; i < 6000; i++) begin
      if (n1 < 0 && sig_out === x1) n1 = i;
      if (n2 < 0 && sig_out2 === x2) n2 = i;
      if (n1 >= 0 && n2 >= 0) return;
      @(posedge pclk);
    end
    fail("output stuck");
    results();
  endtask : meas

  // one random code held 1 to 3 cycles first: the filter must restart and skip it
  task automatic set_code(input logic [3:0] c);
    logic [31:0] q;
    logic        e;
    int          t0;
    int          lat;
    lat = 16 * ((int'(c) > cur_code ? int'(c) - cur_code : cur_code - int'(c)) + 6);
    @(posedge pclk);
    raw_code <= 4'($random(seed));
    repeat (1 + $unsigned($random(seed)) % 3) @(posedge pclk);
    raw_code <= c;
    t0 = cyc;
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, `EDQ_OFS_STATUS, 32'h0, q, e);
      if (q[3:0] === c) begin
        chk_r(cyc - t0, lat - 4, lat + 12, "code delay");
        cur_code = int'(c);
        return;
      end
      chk_v(32'(q[3:0]), 32'(cur_code), "code hold");
    end
    fail("code not taken");
    results();
  endtask : set_code

  // ==========
  // main sequence
  initial begin
    logic [31:0] q;
    logic        e;
    logic [3:0]  c;
    logic        edge_polarity_bit;
    int          r;
    int          n1;
    int          n2;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `EDQ_OFS_PERIOD, 32'h0, q, e);
    chk_v(q, 32'(`EDQ_PERIOD_RST), "period reset");
    apb(1'b1, `EDQ_OFS_PERIOD, 32'h1, q, e);
    apb(1'b1, 8'h08, 32'h5, q, e);
    chk_v(32'(e), 32'h1, "unmapped wr");
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk_v(q, 32'h0, "unmapped rd");
    chk_v(32'(e), 32'h1, "unmapped err");
    apb(1'b0, `EDQ_OFS_PERIOD, 32'h0, q, e);
    chk_v(q, 32'h1, "period");
    chk_v(32'(e), 32'h0, "mapped err");
    $display("test bus done");
    src.drive(1'b1, 0);
    meas(1'b1, 1'b1, n1, n2);
    chk_r(n1, 400, 720, "start-up");
    chk_r(n2, n1, n1, "start copy");
    apb(1'b1, `EDQ_OFS_STATUS, 32'hFF, q, e);
    apb(1'b0, `EDQ_OFS_STATUS, 32'h0, q, e);
    chk_v(q, 32'h31, "status");
    $display("test start done");
    foreach (codes[k]) begin
      c = codes[k];
      edge_polarity_bit = c[3];
      r = ratio(c);
      set_code(c);
      src.drive(edge_polarity_bit, r + 12);
      chk_v(32'(sig_out), 32'(edge_polarity_bit), "rest 1");
      chk_v(32'(sig_out2), 32'h0, "rest 2");
      if (r >= 8) begin
        src.drive(~edge_polarity_bit, 1 + $unsigned($random(seed)) % (r / 2));
        src.drive(edge_polarity_bit, r + 4);
        chk_v(32'(sig_out), 32'(edge_polarity_bit), "glitch 1");
        chk_v(32'(sig_out2), 32'h0, "glitch 2");
        src.drive(~edge_polarity_bit, r / 2);
        src.drive(edge_polarity_bit, 2);
      end
      src.drive(~edge_polarity_bit, 0);
      meas(~edge_polarity_bit, 1'b1, n1, n2);
      chk_r(n1, r, r + 8, "delay 1");
      chk_r(n2, r, r + 8, "delay 2");
      src.drive(edge_polarity_bit, 0);
      meas(edge_polarity_bit, 1'b0, n1, n2);
      chk_r(n1, 1, 6, "pass 1");
      chk_r(n2, r, r + 8, "width 2");
      $display("test code %0d done", c);
    end
    apb(1'b1, `EDQ_OFS_PERIOD, 32'h0, q, e);
    src.drive(1'b1, 100);
    chk_v(32'(sig_out), 32'h0, "stalled");
    chk_v(32'(sig_out2), 32'h0, "stalled 2");
    apb(1'b1, `EDQ_OFS_PERIOD, 32'h1, q, e);
    meas(1'b1, 1'b1, n1, n2);
    chk_r(n1, 1, 16, "resumed");
    chk_r(n2, 1, 16, "resumed 2");
    $display("test stall done");
    results();
  end

endmodule : tb_edge_delay_qualifier
